// *** logic/hvia_defs.svh ***
// Constants for the high voltage indirect register access block
//
// Operation
// - Codes 0x00-0x03 read indirect registers into data
// - Codes 0x08, 0x09 write data low byte
// - Two-wire serial link clocked at 2.56 MHz
// - Command and write data delivered within 10 us
// - Read value reaches data port within 10 us
// - Command bit 0 reads busy until done
// - Command bit 2 reports send outcome
// - Command bit 1 reports receive outcome
// - Outcome flags valid only while not busy
// - Command read returns status, bits 7:3 zero
// - Data port 12 bits, 11:8 read-only command
// - Exactly four indirect registers are reachable
// - Indirect configuration registers 8 bits, reset zero
`ifndef HVIA_DEFS_SVH
`define HVIA_DEFS_SVH
`define HVIA_CMD_ADDR 32'hFFFF0804
`define HVIA_DATA_ADDR 32'hFFFF080C
`define HVIA_IRQ_STAT_ADDR 32'hFFFF0810
`define HVIA_IRQ_MASK_ADDR 32'hFFFF0814
`define HVIA_RD_CFG0 8'h00
`define HVIA_RD_CFG1 8'h01
`define HVIA_RD_STAT 8'h02
`define HVIA_RD_MON 8'h03
`define HVIA_WR_CFG0 8'h08
`define HVIA_WR_CFG1 8'h09
`define HVIA_BUSY_BIT 0
`define HVIA_RX_OK_BIT 1
`define HVIA_TX_OK_BIT 2
`define HVIA_IRQ_DONE_BIT 0
`define HVIA_IRQ_FAIL_BIT 1
`define HVIA_DATA_RESET 12'h000
`define HVIA_CLK_KHZ 200000
`define HVIA_SCLK_KHZ 2560
`define HVIA_HALF_CYC (`HVIA_CLK_KHZ / (2 * `HVIA_SCLK_KHZ))
`define HVIA_LAT_US 10
`define HVIA_LAT_CYC (`HVIA_LAT_US * `HVIA_CLK_KHZ / 1000)
`endif

// *** logic/hvia_pkg.sv ***
// Types for the high voltage indirect register access block
package hvia_pkg;
    // Link sequencer states
    typedef enum logic [4:0] {
        HVIA_IDLE = 5'b00001,
        HVIA_CMD = 5'b00010,
        HVIA_WDAT = 5'b00100,
        HVIA_ACK = 5'b01000,
        HVIA_RDAT = 5'b10000
    } hvia_state_t;

    // Whole state of the block
    typedef struct packed {
        hvia_state_t st;
        logic [5:0] div;
        logic sclk;
        logic [3:0] bitn;
        logic [8:0] shreg;
        logic oe;
        logic [7:0] cmd;
        logic [11:0] data;
        logic busy;
        logic tx_ok;
        logic rx_ok;
        logic sync1;
        logic sync2;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] prdata;
        logic pslverr;
    } hvia_regs_t;
endpackage

// *** logic/hvia_top.sv ***
// Command interpreter and serial link to the high voltage die
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "hvia_defs.svh"

module hvia_top
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic hv_sclk,
    output logic hv_sdata_o,
    output logic hv_sdata_oe,
    input wire logic hv_sdata_i
);
    localparam logic [5:0] HALF_M1 = 6'(`HVIA_HALF_CYC - 1);
    localparam logic [3:0] LAST8 = 4'h7;
    localparam logic [3:0] LAST9 = 4'h8;

    // Command class: 1 = read, 2 = write, 0 = undefined
    function automatic logic [1:0] cmd_kind(input logic [7:0] c);
        logic [1:0] k;
        k = 2'h0;
        case (c)
            `HVIA_RD_CFG0, `HVIA_RD_CFG1,
            `HVIA_RD_STAT, `HVIA_RD_MON: k = 2'h1;
            `HVIA_WR_CFG0, `HVIA_WR_CFG1: k = 2'h2;
            default: k = 2'h0;
        endcase
        return k;
    endfunction

    // Address decode, shared by read capture and write
    function automatic logic [1:0] addr_sel(input logic [31:0] a,
                                            output logic hit);
        logic [1:0] s;
        s = 2'h0;
        hit = 1'b1;
        case (a)
            `HVIA_CMD_ADDR: s = 2'h0;
            `HVIA_DATA_ADDR: s = 2'h1;
            `HVIA_IRQ_STAT_ADDR: s = 2'h2;
            `HVIA_IRQ_MASK_ADDR: s = 2'h3;
            default: hit = 1'b0;
        endcase
        return s;
    endfunction

    hvia_pkg::hvia_regs_t q;
    hvia_pkg::hvia_regs_t n;
    logic setup;
    logic access;
    logic hit;
    logic [1:0] sel;
    logic bit_end;
    logic ev_done;
    logic ev_fail;
    logic [1:0] kind;

    // Bus phases and decode
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign kind = cmd_kind(pwdata[7:0]);

    // Address decode; the hit flag comes back through an argument
    always_comb
    begin
        sel = addr_sel(paddr, hit);
    end

    // Next state
    always_comb
    begin
        n = q;
        ev_done = 1'b0;
        ev_fail = 1'b0;
        bit_end = 1'b0;
        // Synchroniser for the returned data line
        n.sync1 = hv_sdata_i;
        n.sync2 = q.sync1;

        // Serial clock divider, runs only during a frame
        if (q.st != hvia_pkg::HVIA_IDLE)
        begin
            if (q.div == HALF_M1)
            begin
                n.div = 6'h00;
                n.sclk = ~q.sclk;
                bit_end = q.sclk;
            end
            else
            begin
                n.div = q.div + 6'h01;
            end
        end

        // Bit sequencing at each falling serial clock edge
        if (bit_end)
        begin
            case (q.st)
                hvia_pkg::HVIA_CMD:
                begin
                    n.shreg = {q.shreg[7:0], 1'b0};
                    n.bitn = q.bitn + 4'h1;
                    if (q.bitn == LAST8)
                    begin
                        n.bitn = 4'h0;
                        if (q.cmd[3])
                        begin
                            // Write data byte plus even parity
                            n.st = hvia_pkg::HVIA_WDAT;
                            n.shreg = {q.data[7:0], ^q.data[7:0]};
                        end
                        else
                        begin
                            // Release the line to the far end
                            n.st = hvia_pkg::HVIA_RDAT;
                            n.oe = 1'b0;
                        end
                    end
                end
                hvia_pkg::HVIA_WDAT:
                begin
                    n.shreg = {q.shreg[7:0], 1'b0};
                    n.bitn = q.bitn + 4'h1;
                    if (q.bitn == LAST9)
                    begin
                        n.bitn = 4'h0;
                        n.st = hvia_pkg::HVIA_ACK;
                        n.oe = 1'b0;
                    end
                end
                hvia_pkg::HVIA_ACK:
                begin
                    // Far end acknowledges a write with a high bit
                    n.st = hvia_pkg::HVIA_IDLE;
                    n.busy = 1'b0;
                    n.sclk = 1'b0;
                    n.tx_ok = q.sync2;
                    n.rx_ok = q.sync2;
                    ev_done = 1'b1;
                    ev_fail = ~q.sync2;
                end
                hvia_pkg::HVIA_RDAT:
                begin
                    n.shreg = {q.shreg[7:0], q.sync2};
                    n.bitn = q.bitn + 4'h1;
                    if (q.bitn == LAST9)
                    begin
                        n.bitn = 4'h0;
                        n.st = hvia_pkg::HVIA_IDLE;
                        n.busy = 1'b0;
                        n.sclk = 1'b0;
                        n.tx_ok = 1'b1;
                        // Parity check decides the receive outcome
                        n.rx_ok = ~^{q.shreg[7:0], q.sync2};
                        ev_done = 1'b1;
                        ev_fail = ^{q.shreg[7:0], q.sync2};
                        // Read value plus the command that fetched it
                        n.data = {q.cmd[3:0], q.shreg[7:0]};
                    end
                end
                default:
                begin
                    n.st = hvia_pkg::HVIA_IDLE;
                end
            endcase
        end

        // Read data and error captured in the setup cycle
        if (setup)
        begin
            n.pslverr = ~hit;
            n.prdata = 32'h0000_0000;
            if (hit)
            begin
                case (sel)
                    2'h0: n.prdata = {29'h0, q.tx_ok, q.rx_ok,
                                      q.busy};
                    2'h1: n.prdata = {20'h0_0000, q.data};
                    2'h2: n.prdata = {30'h0, q.irq_stat};
                    default: n.prdata = {30'h0, q.irq_mask};
                endcase
            end
        end

        // Register writes in the access cycle
        if (access && pwrite && hit)
        begin
            case (sel)
                2'h0:
                begin
                    // Commands while busy are dropped
                    if (!q.busy && kind != 2'h0)
                    begin
                        n.cmd = pwdata[7:0];
                        n.st = hvia_pkg::HVIA_CMD;
                        n.busy = 1'b1;
                        n.oe = 1'b1;
                        n.div = 6'h00;
                        n.sclk = 1'b0;
                        n.bitn = 4'h0;
                        n.shreg = {pwdata[7:0], 1'b0};
                        if (kind == 2'h2)
                        begin
                            n.data[11:8] = pwdata[3:0];
                        end
                    end
                end
                2'h1:
                begin
                    // Data stays stable while a frame uses it
                    if (!q.busy)
                    begin
                        n.data[7:0] = pwdata[7:0];
                    end
                end
                2'h3: n.irq_mask = pwdata[1:0];
                default: n.irq_stat = q.irq_stat;
            endcase
        end

        // Sticky events, read clears, a new event wins
        if (access && !pwrite && hit && sel == 2'h2)
        begin
            n.irq_stat = 2'h0;
        end
        n.irq_stat[`HVIA_IRQ_DONE_BIT] = n.irq_stat[`HVIA_IRQ_DONE_BIT]
                                         | ev_done;
        n.irq_stat[`HVIA_IRQ_FAIL_BIT] = n.irq_stat[`HVIA_IRQ_FAIL_BIT]
                                         | ev_fail;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q.st <= hvia_pkg::HVIA_IDLE;
            q.div <= 6'h00;
            q.sclk <= 1'b0;
            q.bitn <= 4'h0;
            q.shreg <= 9'h000;
            q.oe <= 1'b0;
            q.cmd <= 8'h00;
            q.data <= `HVIA_DATA_RESET;
            q.busy <= 1'b0;
            q.tx_ok <= 1'b0;
            q.rx_ok <= 1'b0;
            q.sync1 <= 1'b0;
            q.sync2 <= 1'b0;
            q.irq_stat <= 2'h0;
            q.irq_mask <= 2'h0;
            q.prdata <= 32'h0000_0000;
            q.pslverr <= 1'b0;
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs
    assign prdata = q.prdata;
    assign pslverr = access & q.pslverr;
    assign pready = access;
    assign irq = |(q.irq_stat & q.irq_mask);
    assign hv_sclk = q.sclk;
    assign hv_sdata_o = q.shreg[8];
    assign hv_sdata_oe = q.oe;
endmodule

// *** test/hvia_far_end.sv ***
// Behavioural register logic at the far end of the link
`timescale 1ns/1ps
module hvia_far_end
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic oe,
    input wire logic sd,
    input wire logic bad,
    output logic sd_out
);
    logic [7:0] r [4];
    logic [7:0] cmd;
    logic [8:0] sh;
    logic [8:0] w;
    int n = 99;
    initial sd_out = 1'b0;
    // Config pair clears on reset, status pair fixed
    always @(posedge clk)
        if (rst)
            r = '{8'h00, 8'h00, 8'h5A, 8'hC3};
    // Frame starts when the device takes the line
    always @(posedge oe)
        n = 0;
    // Sample on the rising clock, MSB first
    always @(posedge sclk)
    begin
        if (n < 8)
            cmd = {cmd[6:0], sd};
        else
            sh = {sh[7:0], sd};
        if (n == 16 && cmd[3] && ^sh == 1'b0)
            r[cmd[0]] = sh[8:1];
        n++;
    end
    // Drive after the falling clock; a released line toggles
    always @(negedge sclk)
    begin
        w = {r[cmd[1:0]], ^r[cmd[1:0]] ^ bad};
        if (!cmd[3] && n >= 8 && n <= 16)
            sd_out <= w[16 - n];
        else if (cmd[3] && n == 17)
            sd_out <= (^sh == 1'b0) ^ bad;
        else
            sd_out <= ~sd_out;
    end
endmodule

// *** test/hvia_top_assertions.sv ***
// Port checks for the indirect access block
`timescale 1ns/1ps
`include "hvia_defs.svh"
module hvia_top_chk
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hv_sclk,
    input wire logic hv_sdata_o,
    input wire logic hv_sdata_oe
);
    logic [6:0] run_q;
    logic lv_q;
    logic acc, wr_c, rd_c, rd_d, ok, idle, hit;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Decode; link idle once the clock rests low 41 cycles
    assign acc = psel && penable;
    assign wr_c = acc && pwrite && paddr == `HVIA_CMD_ADDR;
    assign rd_c = acc && !pwrite && paddr == `HVIA_CMD_ADDR;
    assign rd_d = acc && !pwrite && paddr == `HVIA_DATA_ADDR;
    assign ok = pwdata[7:0] inside {[8'h00:8'h03], 8'h08, 8'h09};
    assign idle = !hv_sdata_oe && !hv_sclk && run_q > 7'h28;
    assign hit = paddr inside {`HVIA_CMD_ADDR, `HVIA_DATA_ADDR,
        `HVIA_IRQ_STAT_ADDR, `HVIA_IRQ_MASK_ADDR};
    // Cycles the serial clock has held its level
    always_ff @(posedge clk)
    begin
        lv_q <= hv_sclk;
        if (srst || hv_sclk != lv_q)
            run_q <= 7'h01;
        else if (run_q != 7'h7F)
            run_q <= run_q + 7'h01;
    end
    // Link and register relations
    property p_clk; $fell(hv_sclk) |-> run_q == 7'h27; endproperty
    a_clk: assert property (p_clk) else $error("clock phase");
    property p_go; wr_c && ok && idle |=> hv_sdata_oe &&
        hv_sdata_o == $past(pwdata[7]); endproperty
    a_go: assert property (p_go) else $error("no frame");
    property p_bad; wr_c && !ok |=> !$rose(hv_sdata_oe); endproperty
    a_bad: assert property (p_bad) else $error("odd frame");
    property p_st; rd_c |-> prdata[31:3] == 29'h0; endproperty
    a_st: assert property (p_st) else $error("status bits");
    property p_dat; rd_d |-> prdata[31:12] == 20'h0; endproperty
    a_dat: assert property (p_dat) else $error("data bits");
    property p_by1; rd_c && $past(hv_sdata_oe) |-> prdata[0]; endproperty
    a_by1: assert property (p_by1) else $error("busy low");
    property p_by0; rd_c && $past(idle) |-> !prdata[0]; endproperty
    a_by0: assert property (p_by0) else $error("busy high");
    property p_rdy; acc |-> pready && pslverr == !hit; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
    cover property ($fell(hv_sdata_oe));
    cover property (wr_c && ok && idle);
    cover property (rd_c && prdata[0]);
endmodule
bind hvia_top hvia_top_chk u_chk
(
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .hv_sclk, .hv_sdata_o, .hv_sdata_oe
);

// *** test/tb_top.sv ***
// Self-checking bench for the indirect access block
`timescale 1ns/1ps
`include "hvia_defs.svh"
module tb_top;
    localparam logic [31:0] CA = `HVIA_CMD_ADDR;
    localparam logic [31:0] DA = `HVIA_DATA_ADDR;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic bad = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, hv_sclk, hv_sdata_o, hv_sdata_oe, fe, err;
    wire logic hv_sdata_i = hv_sdata_oe ? hv_sdata_o : fe;
    logic [7:0] ev [4] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3};
    int num_errors = 0;
    int comparisons = 0;
    realtime t0;
    hvia_top dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .hv_sclk, .hv_sdata_o,
        .hv_sdata_oe, .hv_sdata_i);
    hvia_far_end far (.clk, .rst(srst), .sclk(hv_sclk), .oe(hv_sdata_oe),
        .sd(hv_sdata_i), .bad, .sd_out(fe));
    initial forever #2.5 clk = ~clk;
    // One bus transfer, held until pready
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // Command with busy seen, then polled to the end
    task automatic run(input logic [7:0] c, d);
        int n = 0;
        apb(1'b1, DA, {24'h0, d});
        repeat (45) @(posedge clk);
        apb(1'b1, CA, {24'h0, c});
        t0 = $realtime;
        apb(1'b0, CA, 32'h0);
        check(rd & 32'h1, 32'h1);
        while (rd[0] !== 1'b0 && n++ < 1000)
            apb(1'b0, CA, 32'h0);
        check({31'h0, $realtime - t0 < 10000.0}, 32'h1);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #400000;
        num_errors++;
        report_and_stop();
    end
    // Test sequence
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        check(32'(far.r[0]), 32'h0);
        apb(1'b0, CA, 32'h0);
        check(rd, 32'h0);
        $display("end reset");
        for (int i = 0; i < 2; i++)
        begin
            run(8'h08 + 8'(i), ev[i]);
            check(rd, 32'h6);
            check(32'(far.r[i]), 32'(ev[i]));
            apb(1'b0, DA, 32'h0);
            check(rd, {20'h0, 4'h8 + 4'(i), ev[i]});
        end
        $display("end write");
        for (int i = 0; i < 4; i++)
        begin
            run(8'(i), 8'h00);
            check(rd, 32'h6);
            apb(1'b0, DA, 32'h0);
            check(rd, {20'h0, 4'(i), ev[i]});
        end
        $display("end read");
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, CA, {24'h0, 8'h04 + 8'(i * 6)});
            apb(1'b0, CA, 32'h0);
            check(rd, 32'h6);
        end
        apb(1'b1, DA, 32'h011);
        apb(1'b0, DA, 32'h0);
        check(rd, 32'h311);
        $display("end refuse");
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `HVIA_IRQ_MASK_ADDR, 32'h2);
        bad <= 1'b1;
        run(8'h08, 8'h66);
        check({rd[30:0], irq}, 32'h1);
        run(8'h01, 8'h00);
        check(rd, 32'h4);
        apb(1'b0, `HVIA_IRQ_STAT_ADDR, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, `HVIA_IRQ_STAT_ADDR, 32'h0);
        check({rd[30:0], irq}, 32'h0);
        bad <= 1'b0;
        apb(1'b0, 32'hFFFF0808, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("end fault");
        report_and_stop();
    end
endmodule
